// ### verilog/card_block_ctrl.sv
// Card side block numbering, acknowledgement and chaining for a proximity card link.
// Assumes the front end strips framing and CRC, flags CRC faults on the last byte,
// and raises activate once when the reader activates the card.
// Function
// - Card block number starts at one per activation
// - Card toggles number on each received I-block
// - Card toggles on mismatched ACK, never on NAK
// - Card transmits only after receiving a block
// - Chained I-block is answered with R(ACK)
// - Answer DESELECT only; other S-blocks unsupported
// - Unchained I-block gets an affirmative I-block reply
// - Matching ACK or NAK resends last I-block
// - Mismatched NAK is answered with R(ACK)
// - Mismatched ACK while chaining sends next segment
// - Commands and responses travel as APDUs in INF
// - R-blocks carry no INF; acknowledge latest block
// - Data field at most 256 bytes
`timescale 1ns/10ps
`default_nettype none
module card_block_ctrl #(
    parameter int RESP_DEPTH = card_block_pkg::RESP_DEPTH_DEF,
    parameter int SEG_LEN = card_block_pkg::SEG_LEN_DEF
) (
    input wire logic clk,                // System clock, 125 MHz
    input wire logic rst_b,              // Synchronous reset, active low
    input wire logic activate,           // Card activated by reader, pulse
    input wire logic rx_valid,           // Received byte strobe
    input wire logic [7:0] rx_data,      // Received byte
    input wire logic rx_last,            // Last byte of received frame
    input wire logic rx_err,             // Frame fault, with rx_last
    output logic apdu_valid,             // Command APDU byte strobe
    output logic [7:0] apdu_data,        // Command APDU byte
    output logic apdu_first,             // First byte of an APDU
    output logic apdu_end,               // Command APDU complete, pulse
    output logic apdu_abort,             // Drop bytes of the current block
    output logic cla_err,                // Class byte not zero, pulse
    input wire logic resp_valid,         // Response byte strobe
    input wire logic [7:0] resp_data,    // Response byte, data then SW1 SW2
    input wire logic resp_last,          // Last response byte (SW2)
    output logic resp_ready,             // Response byte accepted
    output logic tx_valid,               // Transmit byte available
    output logic [7:0] tx_data,          // Transmit byte
    output logic tx_last,                // Last byte of transmit frame
    input wire logic tx_ready,           // Front end takes byte
    output logic halted                  // Deselected or not yet activated
);
    import card_block_pkg::*;

    localparam int LW = $clog2(RESP_DEPTH) + 1;
    localparam logic [LW-1:0] SEG_W = LW'(SEG_LEN);
    localparam logic [LW-1:0] DEPTH_W = LW'(RESP_DEPTH);

    typedef struct packed {
        ctrl_state_e st;
        tx_kind_e kind;
        logic bn;
        logic have_i;
        logic rx_bad;
        logic cmd_first;
        logic blk_first;
        logic [8:0] rx_cnt;
        logic [7:0] pcb;
        logic [LW-1:0] resp_len;
        logic [LW-1:0] seg_base;
        logic [LW-1:0] tx_idx;
        logic [7:0] apdu_data;
        logic apdu_valid;
        logic apdu_first;
        logic apdu_end;
        logic apdu_abort;
        logic cla_err;
    } ctrl_s;

    ctrl_s r, n;
    logic [7:0] mem [RESP_DEPTH];
    logic [LW-1:0] seg_left, seg_n, rd_addr;
    logic card_chain, pcb_legal, fwd_inf, same_bn, frame_bad;
    logic [7:0] pcb_now, tx_byte;

    byte_stream_if #(.W(8)) txq();

    // Reserved PCB bits must match; CID and NAD are refused, S accepts DESELECT only
    function automatic logic pcb_ok(input logic [7:0] p);
        logic ok;
        ok = 1'b0;
        case (p[7:6])
            PCB_TYPE_I: begin
                ok = !p[TYPE6_BIT] && (p[3:1] == PCB_LOW_FIXED);
            end
            PCB_TYPE_R: begin
                ok = p[TYPE6_BIT] && (p[3:1] == PCB_LOW_FIXED);
            end
            PCB_TYPE_S: begin
                ok = (p == PCB_S_DESEL);
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction

    // The first byte of a frame is its PCB, later bytes are INF
    assign pcb_now = (r.rx_cnt == 9'h000) ? rx_data : r.pcb;
    assign pcb_legal = pcb_ok(pcb_now);
    assign fwd_inf = (r.rx_cnt != 9'h000) && (pcb_now[7:6] == PCB_TYPE_I) && pcb_legal;
    assign same_bn = (pcb_now[0] == r.bn);

    // Segment bookkeeping for card chaining of long responses
    assign seg_left = r.resp_len - r.seg_base;
    assign card_chain = (seg_left > SEG_W);
    assign seg_n = card_chain ? SEG_W : seg_left;
    assign rd_addr = r.seg_base + r.tx_idx - LW'(1);

    // Transmit byte: PCB first, then the stored segment for I-blocks
    always_comb begin
        case (r.kind)
            TX_I: begin
                if (r.tx_idx == '0) begin
                    tx_byte = PCB_I_BASE | {3'h0, card_chain, 3'h0, r.bn};
                end else begin
                    tx_byte = mem[rd_addr[LW-2:0]];
                end
            end
            TX_ACK: begin
                tx_byte = PCB_R_ACK | {7'h00, r.bn};
            end
            default: begin
                tx_byte = PCB_S_DESEL;
            end
        endcase
    end

    assign txq.valid = (r.st == ST_TX);
    assign txq.data = tx_byte;
    assign txq.last = (r.kind != TX_I) || (r.tx_idx == seg_n);
    assign resp_ready = (r.st == ST_APP);

    // Block control state machine
    always_comb begin
        n = r;
        n.apdu_valid = 1'b0;
        n.apdu_end = 1'b0;
        n.apdu_abort = 1'b0;
        n.cla_err = 1'b0;
        frame_bad = 1'b0;
        case (r.st)
            ST_IDLE: begin
                // Frames are only taken here, so nothing goes out unprompted
                if (rx_valid) begin
                    n.rx_cnt = (r.rx_cnt == 9'h1FF) ? r.rx_cnt : r.rx_cnt + 9'h001;
                    if (r.rx_cnt == 9'h000) begin
                        n.pcb = rx_data;
                        n.blk_first = r.cmd_first;
                    end
                    if (r.rx_cnt >= DATA_MAX) begin
                        n.rx_bad = 1'b1;
                    end
                    if (fwd_inf) begin
                        n.apdu_valid = 1'b1;
                        n.apdu_data = rx_data;
                        n.apdu_first = r.cmd_first;
                        n.cmd_first = 1'b0;
                        n.cla_err = r.cmd_first && (rx_data != CLA_VALUE);
                    end
                    if (rx_last) begin
                        // R and S blocks with any INF byte are illegal
                        frame_bad = n.rx_bad || rx_err || !pcb_legal ||
                            (pcb_now[7] && (r.rx_cnt != 9'h000));
                        n.rx_cnt = 9'h000;
                        n.rx_bad = 1'b0;
                        n.tx_idx = '0;
                        if (frame_bad) begin
                            // Stay silent; the reader recovers by timeout
                            n.apdu_abort = (r.rx_cnt != 9'h000) && !n.cmd_first;
                            n.cmd_first = (r.rx_cnt == 9'h000) ? r.cmd_first : r.blk_first;
                        end else if (pcb_now[7:6] == PCB_TYPE_I) begin
                            n.bn = ~r.bn;
                            if (pcb_now[CHAIN_BIT]) begin
                                n.kind = TX_ACK;
                                n.st = ST_TX;
                            end else begin
                                n.apdu_end = 1'b1;
                                n.cmd_first = 1'b1;
                                n.resp_len = '0;
                                n.seg_base = '0;
                                n.have_i = 1'b0;
                                n.st = ST_APP;
                            end
                        end else if (pcb_now[7:6] == PCB_TYPE_R) begin
                            if (same_bn) begin
                                // Nothing to resend before the first I-block
                                if (r.have_i) begin
                                    n.kind = TX_I;
                                    n.st = ST_TX;
                                end
                            end else if (pcb_now[NAK_BIT]) begin
                                n.kind = TX_ACK;
                                n.st = ST_TX;
                            end else begin
                                n.bn = ~r.bn;
                                if (card_chain) begin
                                    n.seg_base = r.seg_base + SEG_W;
                                    n.kind = TX_I;
                                    n.st = ST_TX;
                                end
                            end
                        end else begin
                            n.kind = TX_DESEL;
                            n.st = ST_TX;
                        end
                    end
                end
            end
            ST_APP: begin
                // A full store closes the response early to avoid overwrite
                if (resp_valid) begin
                    n.resp_len = r.resp_len + LW'(1);
                    if (resp_last || (r.resp_len == DEPTH_W - LW'(1))) begin
                        n.kind = TX_I;
                        n.tx_idx = '0;
                        n.st = ST_TX;
                    end
                end
            end
            ST_TX: begin
                if (txq.ready) begin
                    n.tx_idx = r.tx_idx + LW'(1);
                    if (txq.last) begin
                        n.tx_idx = '0;
                        n.have_i = r.have_i || (r.kind == TX_I);
                        n.st = (r.kind == TX_DESEL) ? ST_HALT : ST_IDLE;
                    end
                end
            end
            ST_HALT: begin
                n.rx_cnt = 9'h000;
            end
            default: begin
                n.st = ST_HALT;
            end
        endcase
        if (activate) begin
            n.bn = BN_INIT;
            n.st = ST_IDLE;
            n.have_i = 1'b0;
            n.rx_cnt = 9'h000;
            n.rx_bad = 1'b0;
            n.cmd_first = 1'b1;
            n.resp_len = '0;
            n.seg_base = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r <= '0;
            r.st <= ST_HALT;
            r.bn <= BN_INIT;
            r.cmd_first <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Response store; kept out of the state struct so it maps to RAM
    always_ff @(posedge clk) begin
        if (resp_valid && resp_ready) begin
            mem[r.resp_len[LW-2:0]] <= resp_data;
        end
    end

    // Two-entry buffer so a stalled front end loses no byte
    tx_fifo #(.WIDTH(8), .DEPTH(2)) u_tx_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_s(txq.snk),
        .out_valid(tx_valid),
        .out_data(tx_data),
        .out_last(tx_last),
        .out_ready(tx_ready)
    );

    assign apdu_valid = r.apdu_valid;
    assign apdu_data = r.apdu_data;
    assign apdu_first = r.apdu_first;
    assign apdu_end = r.apdu_end;
    assign apdu_abort = r.apdu_abort;
    assign cla_err = r.cla_err;
    assign halted = (r.st == ST_HALT);
endmodule // card_block_ctrl
`default_nettype wire

// ### verilog/card_block_pkg.sv
// Constants and types shared by the contactless block controller, its assertions and its test bench.
// Assumes a front end that delivers de-framed, CRC-checked bytes and reports CRC faults.
package card_block_pkg;
    // Largest data field between start and end of frame
    localparam logic [8:0] DATA_MAX = 9'h100;
    // Response store depth and card chaining segment length
    localparam int RESP_DEPTH_DEF = 256;
    localparam int SEG_LEN_DEF = 64;
    // Protocol control byte codes
    localparam logic [7:0] PCB_I_BASE = 8'h02;
    localparam logic [7:0] PCB_R_ACK = 8'hA2;
    localparam logic [7:0] PCB_S_DESEL = 8'hC2;
    localparam logic [1:0] PCB_TYPE_I = 2'h0;
    localparam logic [1:0] PCB_TYPE_R = 2'h2;
    localparam logic [1:0] PCB_TYPE_S = 2'h3;
    localparam logic [2:0] PCB_LOW_FIXED = 3'h1;
    localparam int CHAIN_BIT = 4;
    localparam int NAK_BIT = 4;
    localparam int TYPE6_BIT = 5;
    // Command class byte value and block number after activation
    localparam logic [7:0] CLA_VALUE = 8'h00;
    localparam logic BN_INIT = 1'b1;

    // Gray along idle -> collect -> transmit -> halt
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_APP = 2'h1,
        ST_TX = 2'h3,
        ST_HALT = 2'h2
    } ctrl_state_e;

    typedef enum logic [1:0] {
        TX_I = 2'h0,
        TX_ACK = 2'h1,
        TX_DESEL = 2'h2
    } tx_kind_e;
endpackage

// ### verilog/byte_stream_if.sv
// Byte stream carrier with valid, ready and end-of-frame marker.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface byte_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic last;
    logic [W-1:0] data;
    modport src(output valid, output data, output last, input ready);
    modport snk(input valid, input data, input last, output ready);
endinterface
`default_nettype wire

// ### verilog/tx_fifo.sv
// Small FIFO between block controller and the transmit front end.
// Assumes DEPTH is a power of two; the sink may stall for any time.
`timescale 1ns/10ps
`default_nettype none
module tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,                // System clock
    input wire logic rst_b,              // Synchronous reset, active low
    byte_stream_if.snk in_s,             // Bytes from the controller
    output logic out_valid,              // Byte available
    output logic [WIDTH-1:0] out_data,   // Byte value
    output logic out_last,               // Last byte of frame
    input wire logic out_ready           // Front end takes byte
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH:0] ent;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } fifo_s;

    fifo_s r, n;
    logic push, pop;

    // Honest full and empty; ready drops when both entries hold data
    assign in_s.ready = (r.cnt != FULL_CNT);
    assign out_valid = (r.cnt != '0);
    assign out_data = r.ent[r.rd][WIDTH-1:0];
    assign out_last = r.ent[r.rd][WIDTH];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_valid && out_ready;

    // Pointer and count update
    always_comb begin
        n = r;
        if (push) begin
            n.ent[r.wr] = {in_s.last, in_s.data};
            n.wr = r.wr + AW'(1);
        end
        if (pop) begin
            n.rd = r.rd + AW'(1);
        end
        if (push && !pop) begin
            n.cnt = r.cnt + (AW + 1)'(1);
        end else if (pop && !push) begin
            n.cnt = r.cnt - (AW + 1)'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule // tx_fifo
`default_nettype wire

// ### testbench/card_block_ctrl_assertions.sv
// Port checks for the card block controller.
// Assumes it is bound into each card_block_ctrl instance.
`timescale 1ns/10ps
`default_nettype none
module card_block_ctrl_assertions #(
    parameter int RESP_DEPTH = 256,
    parameter int SEG_LEN = 64
) (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset
    input wire logic activate, // Activation
    input wire logic rx_valid, // Rx strobe
    input wire logic [7:0] rx_data, // Rx byte
    input wire logic rx_last, // Rx end
    input wire logic rx_err, // Rx fault
    input wire logic apdu_valid, // APDU strobe
    input wire logic [7:0] apdu_data, // APDU byte
    input wire logic apdu_first, // APDU start
    input wire logic apdu_end, // Command done
    input wire logic cla_err, // Class fault
    input wire logic resp_ready, // Response taken
    input wire logic tx_valid, // Tx offered
    input wire logic [7:0] tx_data, // Tx byte
    input wire logic tx_last, // Tx end
    input wire logic tx_ready, // Tx taken
    input wire logic halted // Inactive
);
    import card_block_pkg::*;
    logic first_r, chain_r, seen_r;
    // Frame start, chained I-block and first reception trackers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            first_r <= 1'b1;
            chain_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            if (rx_valid) first_r <= rx_last;
            if (rx_valid && first_r) chain_r <= rx_data[7:5] == 3'h0 && rx_data[4] && rx_data[1];
            if (activate) seen_r <= 1'b0;
            else if (rx_valid && rx_last && !halted) seen_r <= 1'b1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence desel_in_s;
        rx_valid && rx_last && first_r && !rx_err && !halted && rx_data == PCB_S_DESEL;
    endsequence
    sequence desel_out_s;
        ##[1:3] (tx_valid && tx_data == PCB_S_DESEL && tx_last) ##[0:4] halted;
    endsequence
    sequence chain_end_s;
        rx_valid && rx_last && !first_r && chain_r && !rx_err && !halted;
    endsequence
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
        && $stable(tx_last)) else $error("tx byte dropped before taken");
    no_tx_a: assert property (!seen_r |-> !tx_valid)
        else $error("tx before any frame");
    resp_open_a: assert property (apdu_end |-> ##[0:2] resp_ready)
        else $error("no response collection");
    halt_quiet_a: assert property (halted |-> !apdu_valid && !resp_ready && !apdu_end)
        else $error("activity while halted");
    class_flag_a: assert property (cla_err |-> apdu_valid && apdu_first
        && apdu_data != CLA_VALUE) else $error("class flag misplaced");
    desel_reply_a: assert property (desel_in_s |-> desel_out_s)
        else $error("deselect not answered");
    chain_ack_a: assert property (chain_end_s |-> ##[1:3] (tx_valid && tx_last
        && tx_data[7:1] == PCB_R_ACK[7:1])) else $error("chained block not acked");
    r_no_inf_a: assert property (rx_valid && first_r && !halted && rx_data[7:6] == 2'h2
        |-> ##1 !apdu_valid [*3]) else $error("R-block forwarded");
endmodule // card_block_ctrl_assertions
bind card_block_ctrl card_block_ctrl_assertions #(.RESP_DEPTH(RESP_DEPTH), .SEG_LEN(SEG_LEN))
    card_block_ctrl_assertions_inst (.clk, .rst_b, .activate, .rx_valid, .rx_data, .rx_last,
    .rx_err, .apdu_valid, .apdu_data, .apdu_first, .apdu_end, .cla_err, .resp_ready,
    .tx_valid, .tx_data, .tx_last, .tx_ready, .halted);
`default_nettype wire

// ### testbench/reader_model.sv
// Reader side model: sends frames, collects replies, keeps its own block number.
// Assumes half duplex use by one caller at a time.
`timescale 1ns/10ps
`default_nettype none
module reader_model (
    input wire logic clk, // Clock
    output logic activate, // Activation
    output logic rx_valid, // Byte strobe
    output logic [7:0] rx_data, // Byte
    output logic rx_last, // Frame end
    output logic rx_err, // Frame fault
    input wire logic tx_valid, // Card byte offered
    input wire logic [7:0] tx_data, // Card byte
    input wire logic tx_last, // Card frame end
    output logic tx_ready // Byte taken
);
    logic bn_r, slow;
    logic [1:0] cnt_r;
    logic [7:0] rxq[$];
    int nfr;
    initial begin
        {activate, rx_valid, rx_last, rx_err, tx_ready, bn_r, slow} = 7'h00;
        rx_data = 8'h00;
        cnt_r = 2'h0;
        nfr = 0;
    end
    // A slow reader takes one byte in four so the buffer fills
    always @(posedge clk) begin
        cnt_r <= cnt_r + 2'h1;
        tx_ready <= !slow || cnt_r == 2'h0;
        if (tx_valid && tx_ready) begin
            rxq.push_back(tx_data);
            if (tx_last) nfr++;
        end
    end
    task automatic activate_card();
        @(posedge clk);
        activate <= 1'b1;
        bn_r = 1'b0;
        @(posedge clk);
        activate <= 1'b0;
    endtask
    // Frames start with the control byte and go out one byte per clock
    task automatic send(input logic [7:0] q[$], input logic err);
        foreach (q[i]) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= q[i];
            rx_last <= i == q.size() - 1;
            rx_err <= err && i == q.size() - 1;
        end
        @(posedge clk);
        {rx_valid, rx_last, rx_err} <= 3'h0;
        rx_data <= ~rx_data; // Released line shows no stale byte
    endtask
    task automatic get_frame(output logic [7:0] f[$]);
        for (int k = 0; k < 400 && nfr == 0; k++) @(posedge clk);
        f = rxq;
        rxq.delete();
        nfr = 0;
        // Matching I-block or R(ACK) moves the reader on
        if (f.size() > 0 && (f[0][7:5] == 3'h0 || f[0][7:4] == 4'hA) && f[0][0] == bn_r)
            bn_r = !bn_r;
    endtask
endmodule // reader_model
`default_nettype wire

// ### testbench/card_block_ctrl_test.sv
// Self-checking bench for the card block controller.
// Assumes reader_model drives the frame side; the bench plays the response source.
`timescale 1ns/10ps
`default_nettype none
module card_block_ctrl_test;
    import card_block_pkg::*;
    localparam int SEG = 4; // Short segments force card chaining
    logic clk, rst_b, activate, rx_valid, rx_last, rx_err, resp_valid, resp_last, resp_ready;
    logic apdu_valid, apdu_first, apdu_end, apdu_abort, cla_err, tx_valid, tx_last, tx_ready;
    logic halted, cbn;
    logic [7:0] rx_data, resp_data, apdu_data, tx_data, seed;
    logic [7:0] aq[$];
    int n_errors, total_checks, n_end, n_abort, n_cla;
    card_block_ctrl #(.RESP_DEPTH(256), .SEG_LEN(SEG)) card_block_ctrl_inst (.clk, .rst_b,
        .activate, .rx_valid, .rx_data, .rx_last, .rx_err, .apdu_valid, .apdu_data, .apdu_first,
        .apdu_end, .apdu_abort, .cla_err, .resp_valid, .resp_data, .resp_last, .resp_ready,
        .tx_valid, .tx_data, .tx_last, .tx_ready, .halted);
    reader_model reader_model_inst (.clk, .activate, .rx_valid, .rx_data, .rx_last, .rx_err,
        .tx_valid, .tx_data, .tx_last, .tx_ready);
    initial clk = 1'b0;
    always #4 clk = ~clk;
    // Record forwarded command bytes and pulses
    always @(posedge clk) begin
        if (apdu_valid) aq.push_back(apdu_data);
        n_end += int'(apdu_end);
        n_abort += int'(apdu_abort);
        n_cla += int'(cla_err);
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] pcb_i(input logic ch, input logic bn);
        return PCB_I_BASE | {3'h0, ch, 3'h0, bn};
    endfunction
    function automatic logic [7:0] pcb_r(input logic nak, input logic bn);
        return PCB_R_ACK | {3'h0, nak, 3'h0, bn};
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic expect_frame(input logic [7:0] e[$]);
        logic [7:0] f[$];
        reader_model_inst.get_frame(f);
        check("reply length", 8'(f.size()), 8'(e.size()));
        foreach (e[i]) check("reply byte", i < f.size() ? f[i] : ~e[i], e[i]);
    endtask
    task automatic respond(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(posedge clk);
            resp_valid <= 1'b1;
            resp_data <= q[i];
            resp_last <= i == q.size() - 1;
            @(negedge clk);
            while (resp_ready !== 1'b1) @(negedge clk);
        end
        @(posedge clk);
        {resp_valid, resp_last} <= 2'h0;
        resp_data <= ~resp_data;
    endtask
    // Response split into segments, each after the first released by a mismatched R(ACK)
    task automatic card_reply(input logic [7:0] q[$]);
        logic [7:0] e[$], a[$];
        int k;
        k = 0;
        respond(q);
        while (k < q.size()) begin
            e = {pcb_i(q.size() - k > SEG, cbn)};
            repeat (SEG) if (k < q.size()) e.push_back(q[k++]);
            expect_frame(e);
            if (k < q.size()) begin
                a = {pcb_r(1'b0, reader_model_inst.bn_r)};
                reader_model_inst.send(a, 1'b0);
                cbn = !cbn;
            end
        end
    endtask
    task automatic command(input logic ch, input logic [7:0] inf[$], input logic [7:0] rq[$]);
        logic [7:0] f[$];
        f = inf;
        f.push_front(pcb_i(ch, reader_model_inst.bn_r));
        aq.delete();
        n_end = 0;
        reader_model_inst.send(f, 1'b0);
        cbn = !cbn;
        if (ch) begin
            f = {pcb_r(1'b0, cbn)};
            expect_frame(f);
        end else begin
            for (int k = 0; k < 50 && n_end == 0; k++) @(negedge clk);
            check("command end", 8'(n_end), 8'h01);
            card_reply(rq);
        end
        foreach (inf[i]) check("apdu byte", i < aq.size() ? aq[i] : ~inf[i], inf[i]);
    endtask
    task automatic silent(input logic [7:0] f[$], input logic err);
        reader_model_inst.send(f, err);
        repeat (40) @(posedge clk);
        check("no reply", 8'(reader_model_inst.rxq.size()), 8'h00);
    endtask
    initial begin
        logic [7:0] q[$], r[$];
        {rst_b, resp_valid, resp_last} = 3'h0;
        resp_data = 8'h00;
        {n_errors, total_checks, n_end, n_abort, n_cla} = '0;
        seed = 8'h48;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        check("halted at reset", {7'h0, halted}, 8'h01);
        reader_model_inst.activate_card();
        cbn = BN_INIT;
        // Response longer than a segment, then matching NAK and ACK
        q = '{CLA_VALUE, 8'hB0, 8'h00, 8'h00, 8'h04};
        command(1'b0, q, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h90, 8'h00});
        for (int n = 0; n < 2; n++) begin
            q = {pcb_r(n[0] == 1'b0, cbn)};
            reader_model_inst.send(q, 1'b0);
            expect_frame('{pcb_i(1'b0, cbn), 8'h90, 8'h00});
        end
        // Reader chaining with a mismatched NAK in the middle
        command(1'b1, '{CLA_VALUE, 8'hD6, 8'h00}, r);
        q = {pcb_r(1'b1, reader_model_inst.bn_r)};
        reader_model_inst.send(q, 1'b0);
        expect_frame('{pcb_r(1'b0, cbn)});
        command(1'b0, '{8'h00, 8'h01, 8'h5A}, '{8'h90, 8'h00});
        command(1'b0, '{8'h80, 8'hB0, 8'h00, 8'h00}, '{8'h6E, 8'h00});
        check("class flag", 8'(n_cla), 8'h01);
        // Random commands, the reader stalling on odd seeds
        for (int t = 0; t < 6; t++) begin
            seed = lfsr(seed);
            reader_model_inst.slow = seed[0];
            q = '{CLA_VALUE, seed, 8'h00, seed & 8'h7F, 8'(seed[2:0])};
            if (q[4] == 8'h00) q = q[0:3];
            r.delete();
            repeat (seed[2:0]) begin
                seed = lfsr(seed);
                r.push_back(seed);
            end
            r.push_back(8'h90);
            r.push_back(8'h00);
            command(1'b0, q, r);
        end
        // Faulty, unsupported and malformed frames stay unanswered
        silent('{pcb_i(1'b0, reader_model_inst.bn_r), CLA_VALUE}, 1'b1);
        check("abort flag", 8'(n_abort > 0), 8'h01);
        reader_model_inst.send('{pcb_r(1'b1, reader_model_inst.bn_r)}, 1'b0);
        expect_frame('{pcb_r(1'b0, cbn)});
        q = {pcb_i(1'b0, reader_model_inst.bn_r)};
        repeat (256) q.push_back(CLA_VALUE);
        silent(q, 1'b0);
        silent('{8'hF2, 8'h01}, 1'b0);
        silent('{pcb_r(1'b0, cbn), 8'h00}, 1'b0);
        reader_model_inst.send('{PCB_S_DESEL}, 1'b0);
        expect_frame('{PCB_S_DESEL});
        check("halted", {7'h0, halted}, 8'h01);
        silent('{pcb_i(1'b0, 1'b0), CLA_VALUE}, 1'b0);
        reader_model_inst.activate_card();
        cbn = BN_INIT;
        command(1'b0, '{CLA_VALUE, 8'hA4, 8'h04, 8'h00}, '{8'h90, 8'h00});
        complete_run();
    end
    // A run needs under a thousand cycles; this limit cuts a hang short
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule // card_block_ctrl_test
`default_nettype wire
